// [rtl/osc_pkg.sv]
// shared constants for the oscillator select and clock output block
package osc_pkg;
   // non-volatile oscillator option codes
   typedef enum logic [2:0] {
      OSC_XTAL_LOW  = 3'h0,
      OSC_XTAL_MED  = 3'h1,
      OSC_XTAL_HIGH = 3'h2,
      OSC_RC        = 3'h3,
      OSC_EXT       = 3'h4
   } osc_src_t;

   // restart state machine, gray coded along the wake path except the START to RUN step
   typedef enum logic [1:0] {
      OSC_RUN   = 2'h0,
      OSC_STOP  = 2'h1,
      OSC_START = 2'h3
   } osc_state_t;

   localparam logic [7:0]  DIV_RESET      = 8'h00;
   localparam logic [2:0]  CLKOUT_DIV     = 3'h6;
   localparam logic [2:0]  CLKOUT_HALF    = 3'h3;
   localparam logic [10:0] WAKE_XTAL      = 11'h0400;
   localparam logic [10:0] WAKE_RC_EXT    = 11'h0100;
   localparam int          RC_FREQ_KHZ    = 6000;
   localparam int          SYS_FREQ_KHZ   = 40000;
endpackage : osc_pkg

// [rtl/osc_if.sv]
// tick bundle between the clock control core and the clock output divider
`timescale 1ns/100ps
interface osc_if;
   logic cpuTick;
   logic outEnable;
   logic clkOut;
   modport ctrl (output cpuTick, output outEnable, input clkOut);
   modport div  (input cpuTick, input outEnable, output clkOut);
endinterface : osc_if

// [rtl/osc_clkout_div.sv]
// divide-by-six generator for the clock output pin
`timescale 1ns/100ps
module osc_clkout_div (
   input wire logic sys_clk,
   input wire logic rst_n,
   osc_if.div       link
);
   logic [2:0] phase_ff;
   logic       out_ff;
   logic       wrap;

   assign wrap = (phase_ff == osc_pkg::CLKOUT_DIV - 3'h1);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff <= 3'h0;
         out_ff   <= 1'b0;
      end else if (!link.outEnable) begin
         phase_ff <= 3'h0;
         out_ff   <= 1'b0;
      end else if (link.cpuTick) begin
         phase_ff <= wrap ? 3'h0 : phase_ff + 3'h1;
         out_ff   <= (wrap ? 3'h0 : phase_ff + 3'h1) < osc_pkg::CLKOUT_HALF;
      end
   end

   assign link.clkOut = out_ff;
endmodule : osc_clkout_div

// [rtl/osc_clock_ctrl.sv]
// oscillator option decode, cpu clock divider, wake delay and clock output pin
`timescale 1ns/100ps
module osc_clock_ctrl (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] oscOption,
   input  wire logic       standard_timing_select,
   input  wire logic [7:0] cpu_clock_divider,
   input  wire logic       clock_out_enable,
   input  wire logic       clock_in_pin,
   input  wire logic       idleMode,
   input  wire logic       powerDown,
   input  wire logic       portDataOut,
   input  wire logic       portOutEnable_n,
   output logic            cpuClkTick,
   output logic            machineCycleTick,
   output logic            cpuRunning,
   output logic            extClkIn,
   output logic            second_oscillator_pin_o,
   output logic            second_oscillator_pin_oe_n,
   output logic            portPinAvailable,
   output logic            clockOutActive
);
   osc_if link ();

   osc_pkg::osc_src_t   srcSel_ff;
   logic                cfgDone_ff;
   logic                clkSync1_ff;
   logic                clkSync2_ff;
   logic                clkPrev_ff;
   logic [8:0]          divCnt_ff;
   logic [8:0]          nxt_divCnt;
   logic                halfPh_ff;
   logic [2:0]          mcCnt_ff;
   logic [2:0]          nxt_mcCnt;
   logic [10:0]         wakeCnt_ff;
   logic [10:0]         nxt_wakeCnt;
   osc_pkg::osc_state_t state_ff;
   osc_pkg::osc_state_t nxt_state;
   logic                pinO_ff;
   logic                pinOeN_ff;
   logic                nxt_pinO;
   logic                nxt_pinOeN;
   logic                extEdge;
   logic                extSrc;
   logic                oscTick;
   logic                oscRun;
   logic [8:0]          divTop;
   logic                divWrap;
   logic                divTick;
   logic                cpuTickW;
   logic [10:0]         wakeLen;
   logic                wakeDone;
   logic                outAllowed;
   logic                clkOutSel;
   logic                unusedIdle;

   function automatic logic isCrystal(input osc_pkg::osc_src_t s);
      isCrystal = (s == osc_pkg::OSC_XTAL_LOW) || (s == osc_pkg::OSC_XTAL_MED)
                  || (s == osc_pkg::OSC_XTAL_HIGH);
   endfunction : isCrystal

   // configuration is caught once after reset release, never at run time
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         srcSel_ff  <= osc_pkg::OSC_XTAL_LOW;
         cfgDone_ff <= 1'b0;
      end else if (!cfgDone_ff) begin
         srcSel_ff  <= osc_pkg::osc_src_t'(oscOption);
         cfgDone_ff <= 1'b1;
      end
   end

   // external clock is sampled through two flops; limited to below sys_clk/2
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clkSync1_ff <= 1'b0;
         clkSync2_ff <= 1'b0;
      end else begin
         clkSync1_ff <= clock_in_pin;
         clkSync2_ff <= clkSync1_ff;
      end
   end

   // previous synchronised level, only for rising-edge detection
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clkPrev_ff <= 1'b0;
      end else begin
         clkPrev_ff <= clkSync2_ff;
      end
   end

   // rc and crystal oscillators are modelled as one tick per sys_clk
   assign extSrc  = (srcSel_ff == osc_pkg::OSC_EXT);
   assign extEdge = clkSync2_ff & ~clkPrev_ff;
   assign oscTick = extSrc ? extEdge : cfgDone_ff;
   assign oscRun  = (state_ff != osc_pkg::OSC_STOP);

   // counter runs on through a ratio change, so a new ratio needs no halt
   assign divTop     = {cpu_clock_divider, 1'b1};
   assign divWrap    = (divCnt_ff >= divTop);
   assign divTick    = oscRun && oscTick
                       && ((cpu_clock_divider == osc_pkg::DIV_RESET) || divWrap);
   assign cpuTickW   = divTick && (!standard_timing_select || halfPh_ff);
   assign nxt_divCnt = divWrap ? 9'h000 : divCnt_ff + 9'h001;
   assign nxt_mcCnt  = (mcCnt_ff == 3'h5) ? 3'h0 : mcCnt_ff + 3'h1;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_ff <= 9'h000;
      end else if (oscRun && oscTick) begin
         divCnt_ff <= nxt_divCnt;
      end
   end

   // standard timing lets every other divided tick through
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         halfPh_ff <= 1'b0;
      end else if (divTick) begin
         halfPh_ff <= ~halfPh_ff;
      end
   end

   // machine cycle is six cpu ticks, twelve clocks under standard timing
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mcCnt_ff <= 3'h0;
      end else if (cpuTickW) begin
         mcCnt_ff <= nxt_mcCnt;
      end
   end

   // crystals need the longer settle count before the core resumes
   assign wakeLen     = isCrystal(srcSel_ff) ? osc_pkg::WAKE_XTAL : osc_pkg::WAKE_RC_EXT;
   assign wakeDone    = (wakeCnt_ff >= wakeLen - 11'h001) && cpuTickW;
   assign nxt_wakeCnt = (state_ff != osc_pkg::OSC_START) ? 11'h000 : wakeCnt_ff + 11'h001;

   // power down stops the oscillator; the restart waits out the settle count
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         osc_pkg::OSC_RUN:   if (powerDown) nxt_state = osc_pkg::OSC_STOP;
         osc_pkg::OSC_STOP:  if (!powerDown) nxt_state = osc_pkg::OSC_START;
         osc_pkg::OSC_START: if (wakeDone) nxt_state = osc_pkg::OSC_RUN;
         default:            nxt_state = osc_pkg::OSC_RUN;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= osc_pkg::OSC_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wakeCnt_ff <= 11'h000;
      end else if ((state_ff != osc_pkg::OSC_START) || cpuTickW) begin
         wakeCnt_ff <= nxt_wakeCnt;
      end
   end

   // idle does not gate the output; only the enable, a crystal option and a stopped oscillator do
   assign outAllowed     = !isCrystal(srcSel_ff) && cfgDone_ff;
   assign clkOutSel      = clock_out_enable && outAllowed;
   assign link.outEnable = clkOutSel && oscRun;
   assign link.cpuTick   = cpuTickW;

   osc_clkout_div u_div (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .link    (link)
   );

   // crystal modes leave the pin to the oscillator whatever the enable says
   assign nxt_pinO   = clkOutSel ? link.clkOut : (extSrc ? portDataOut : 1'b0);
   assign nxt_pinOeN = clkOutSel ? 1'b0 : (extSrc ? portOutEnable_n : 1'b1);

   // pin drive is registered so the pad never sees a decode glitch
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinO_ff   <= 1'b0;
         pinOeN_ff <= 1'b1;
      end else begin
         pinO_ff   <= nxt_pinO;
         pinOeN_ff <= nxt_pinOeN;
      end
   end

   assign cpuClkTick                 = cpuTickW;
   assign machineCycleTick           = cpuTickW && (mcCnt_ff == 3'h5);
   assign cpuRunning                 = (state_ff == osc_pkg::OSC_RUN);
   assign extClkIn                   = clkSync2_ff;
   assign second_oscillator_pin_o    = pinO_ff;
   assign second_oscillator_pin_oe_n = pinOeN_ff;
   assign portPinAvailable           = extSrc && !clock_out_enable;
   assign clockOutActive             = link.outEnable;

   // idleMode only documents that the output keeps running in idle
   assign unusedIdle = idleMode;
endmodule : osc_clock_ctrl

// [tb/osc_ext_clk_src.sv]
// outside clock source model for the clock-in pin
`timescale 1ns/100ps
module osc_ext_clk_src #(parameter int HALF = 60) (
   input wire logic run,
   output logic     clkPin
);
   initial clkPin = 1'b0;
   // free-running source well under half the system rate, unrelated in phase
   always begin
      #HALF;
      if (run) clkPin = ~clkPin;
   end
endmodule : osc_ext_clk_src

// [tb/osc_ctrl_properties.sv]
// concurrent checks on the clock control ports
`timescale 1ns/100ps
module osc_ctrl_properties (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic [2:0] oscOption,
   input wire logic       standard_timing_select,
   input wire logic [7:0] cpu_clock_divider,
   input wire logic       clock_out_enable,
   input wire logic       idleMode,
   input wire logic       powerDown,
   input wire logic       portDataOut,
   input wire logic       portOutEnable_n,
   input wire logic       cpuClkTick,
   input wire logic       machineCycleTick,
   input wire logic       cpuRunning,
   input wire logic       second_oscillator_pin_o,
   input wire logic       second_oscillator_pin_oe_n,
   input wire logic       portPinAvailable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [1:0]  up_ff;
   logic [2:0]  tc_ff;
   logic [10:0] wk_ff;
   // option latch settles after the first edge, so checks wait for up_ff
   wire         ok   = up_ff == 2'h3;
   wire         exOn = oscOption == 3'h4 && !clock_out_enable;
   wire         c0   = ok && !powerDown && cpu_clock_divider == 8'h00 && oscOption != 3'h4;
   wire  [10:0] wN   = (oscOption < 3'h3) ? osc_pkg::WAKE_XTAL : osc_pkg::WAKE_RC_EXT;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_ff <= 2'h0;
         tc_ff <= 3'h0;
         wk_ff <= 11'h000;
      end else begin
         up_ff <= ok ? up_ff : up_ff + 2'h1;
         tc_ff <= cpuClkTick ? (machineCycleTick ? 3'h0 : tc_ff + 3'h1) : tc_ff;
         wk_ff <= cpuRunning ? 11'h000 : wk_ff + {10'h000, cpuClkTick};
      end
   end
   xtal_pin_idle_a: assert property (oscOption < 3'h3 |-> second_oscillator_pin_oe_n)
      else $error("pin driven in crystal mode");
   ext_port_pass_a: assert property (ok && exOn && $past(exOn) |->
      {second_oscillator_pin_oe_n, second_oscillator_pin_o} ==
      {$past(portOutEnable_n), $past(portDataOut)}) else $error("port not passed");
   port_avail_a: assert property (ok |-> portPinAvailable == exOn)
      else $error("port availability wrong");
   rc_out_on_a: assert property ($rose(clock_out_enable) && oscOption == 3'h3 && ok
      |-> ##[1:8] !second_oscillator_pin_oe_n) else $error("clock output not driven");
   idle_keeps_out_a: assert property (!second_oscillator_pin_oe_n && clock_out_enable
      && oscOption == 3'h3 && $rose(idleMode) |=> !second_oscillator_pin_oe_n)
      else $error("clock output lost in idle");
   div_zero_a: assert property ((c0 && !standard_timing_select) [*4] |-> cpuClkTick)
      else $error("undivided tick missing");
   std_half_a: assert property ((c0 && standard_timing_select) [*6] ##0
      $past(cpuClkTick, 2) |-> !$past(cpuClkTick) && cpuClkTick)
      else $error("standard timing not halved");
   mc_six_a: assert property (machineCycleTick |-> cpuClkTick && tc_ff == 3'h5)
      else $error("machine cycle not six ticks");
   wake_len_a: assert property ($rose(cpuRunning) |-> wk_ff >= wN && wk_ff <= wN + 11'h001)
      else $error("wake delay wrong");
   cover property (machineCycleTick);
   cover property ($rose(cpuRunning));
   cover property (!second_oscillator_pin_oe_n && idleMode);
endmodule : osc_ctrl_properties
bind osc_clock_ctrl osc_ctrl_properties u_osc_ctrl_properties (.*);

// [tb/testbench.sv]
// self-checking bench for the clock control block
`timescale 1ns/100ps
module testbench;
   logic       sys_clk = 0, rst_n = 0, stdSel = 0, en = 0, idle = 0, pd = 0;
   logic       pdo = 0, poe = 1, run = 0, sel = 0, pinQ = 0;
   logic [2:0] opt = 3'h3;
   logic [7:0] div = 8'h00;
   wire        clkIn, tick, mc, running, ext, pinO, pinOe, avail, act;
   int         n_errors = 0, checks = 0, cyc = 0, seed = 21757, g, i;
   wire        probe = sel ? (pinO & ~pinQ) : tick;
   osc_ext_clk_src u_osc_ext_clk_src (.run(run), .clkPin(clkIn));
   osc_clock_ctrl u_osc_clock_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .oscOption(opt),
      .standard_timing_select(stdSel), .cpu_clock_divider(div), .clock_out_enable(en),
      .clock_in_pin(clkIn), .idleMode(idle), .powerDown(pd), .portDataOut(pdo),
      .portOutEnable_n(poe), .cpuClkTick(tick), .machineCycleTick(mc),
      .cpuRunning(running), .extClkIn(ext), .second_oscillator_pin_o(pinO),
      .second_oscillator_pin_oe_n(pinOe), .portPinAvailable(avail), .clockOutActive(act));
   initial forever #12.5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) pinQ <= pinO;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 80000) begin
         n_errors++;
         complete_run();
      end
   end
   function int expP(input logic [7:0] n, input logic s);
      expP = ((n == 8'h00) ? 1 : 2 * (n + 1)) * (s ? 2 : 1);
   endfunction : expP
   task chk(input string w, input logic [31:0] e, input logic [31:0] v);
      checks++;
      if (e !== v) begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", w, e, v);
      end
   endtask : chk
   task boot(input logic [2:0] o);
      @(negedge sys_clk);
      rst_n = 0;
      opt = o;
      en = 0;
      div = 8'h00;
      stdSel = 0;
      run = (o == 3'h4);
      repeat (5) @(negedge sys_clk);
      rst_n = 1;
      repeat (4) @(negedge sys_clk);
   endtask : boot
   // gap in cycles between two events; the timeout bounds the wait
   task gap(input logic s, output int n);
      sel = s;
      do @(negedge sys_clk); while (!probe);
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (!probe);
   endtask : gap
   task complete_run();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   initial begin
      for (i = 0; i < 5; i++) begin
         boot(i[2:0]);
         en = 1;
         repeat (40) @(negedge sys_clk);
         chk("pin oe_n", i < 3, pinOe);
         chk("out active", i >= 3, act);
      end
      $display("option test done");
      boot(3'h3);
      en = 1;
      for (i = 0; i < 8; i++) begin
         div = (i < 2) ? 8'h00 : (i == 2) ? 8'hff : 8'($random(seed)) & 8'h0f;
         stdSel = (i == 0) ? 1'b0 : (i < 3) ? 1'b1 : 1'($random(seed));
         idle = 1'($random(seed));
         gap(0, g);
         gap(0, g);
         chk("tick gap", expP(div, stdSel), g);
         gap(1, g);
         gap(1, g);
         chk("clkout period", 6 * expP(div, stdSel), g);
         chk("oe in idle", 0, pinOe);
      end
      en = 0;
      idle = 1;
      repeat (2) @(negedge sys_clk);
      chk("oe off in idle", 1, pinOe);
      $display("divider test done");
      boot(3'h4);
      for (i = 0; i < 16; i++) begin
         pdo = 1'($random(seed));
         poe = 1'($random(seed));
         @(negedge sys_clk);
         chk("port pass", {poe, pdo}, {pinOe, pinO});
         chk("port free", 1, avail);
      end
      run = 0;
      repeat (4) @(negedge sys_clk);
      chk("clock in sync", clkIn, ext);
      $display("port test done");
      for (i = 2; i < 4; i++) begin
         boot(i[2:0]);
         pd = 1;
         repeat (10) @(negedge sys_clk);
         chk("run in pd", 0, running);
         pd = 0;
         g = 0;
         while (running !== 1'b1 && g < 2000) begin
            @(negedge sys_clk);
            g++;
         end
         chk("long wake", i < 3, g > 600);
      end
      $display("wake test done");
      complete_run();
   end
endmodule : testbench
